/* File: src/reset_source_watchdog_unit.sv */
// Purpose: Reset source collection, reset stretching, cause flags and watchdog
// Assumes: Fuses are static; detector outputs and pins are asynchronous
// Notes: Watchdog oscillator is sampled as a tick stream on the system clock
//
// Function
// RULE_01 - Long low pin pulse resets without clock
// RULE_02 - Pin release starts delay before releasing
// RULE_03 - Level fuse: 111 off, 110/101/100 thresholds
// RULE_04 - Enabled brown-out asserts reset without delay
// RULE_05 - Brown-out recovery restarts through delay counter
// RULE_06 - Ignore brown-out pulses shorter than 2 us
// RULE_07 - Watchdog expiry gives one-cycle pulse, delay follows
// RULE_08 - Debug reset flag bit 4, clear by write
// RULE_09 - Watchdog reset flag bit 3, clear by write
// RULE_10 - Brown-out reset flag bit 2, clear by write
// RULE_11 - Pin reset flag bit 1, clear by write
// RULE_12 - Power-on flag bit 0, only software clears
// RULE_13 - Software reads then clears flags early
// RULE_14 - Reference on for brown-out, comparator or converter
// RULE_15 - Software waits reference start-up before use
// RULE_16 - Watchdog counts its own 1 MHz oscillator
// RULE_17 - Watchdog counter cleared by restart, disable, reset
// RULE_18 - Eight periods; expiry resets the device
// RULE_19 - Safety fuse chooses level 1 or 2
// RULE_20 - Control bits 7..5 read as zero
// RULE_21 - Internal reset stretched by fuse-selected delay
// RULE_22 - Prescale codes select 16K to 2048K ticks
// RULE_23 - Change enable self-clears after four cycles
// RULE_24 - Level 2 keeps enable set, prescale only
// RULE_25 - Detectors assert asynchronously, release synchronised; brown-out here asserts only after its synchroniser and filter
// RULE_26 - Oscillator events cross domains through synchronisers
`timescale 1ns/1ps
module reset_source_watchdog_unit #(
    parameter int WDT_BASE_CYCLES = 16384,   // Watchdog ticks for prescale code 000
    parameter int TOUT_BASE_CYCLES = 4096    // Start-up delay for the shortest fuse setting
) (
    input wire logic ref_clk_i,                                   // System clock, 40 MHz
    input wire logic rst_n_i,                                     // Block reset, async, active low
    input wire logic psel_i,                                      // APB select
    input wire logic penable_i,                                   // APB enable
    input wire logic pwrite_i,                                    // APB write
    input wire logic [rst_wdt_pkg::ADDR_W-1:0] paddr_i,           // APB address
    input wire logic [rst_wdt_pkg::DATA_W-1:0] pwdata_i,          // APB write data
    output logic [rst_wdt_pkg::DATA_W-1:0] prdata_o,              // APB read data
    output logic pready_o,                                        // APB ready
    output logic pslverr_o,                                       // APB error on unmapped address
    input wire logic reset_pin_n_i,                               // External reset pin, active low
    input wire logic por_n_i,                                     // Power-on detector, low in reset
    input wire logic bod_low_i,                                   // Supply below brown-out trigger
    input wire logic debug_reset_i,                               // Debug-port reset register bit
    input wire logic wdt_osc_i,                                   // Watchdog oscillator, 1 MHz
    input wire logic wdt_restart_i,                               // Watchdog restart, one-cycle pulse
    input wire logic [2:0] brownout_level_fuse_i,                 // Brown-out level fuse
    input wire logic watchdog_safety_fuse_i,                      // High when programmed (level 2)
    input wire logic [1:0] startup_time_fuse_i,                   // Start-up time fuse
    input wire logic [3:0] clock_select_fuse_i,                   // Clock select fuse
    input wire logic comparator_bandgap_select_i,                 // Comparator uses reference
    input wire logic adc_enable_i,                                // Converter enabled
    output logic sys_reset_n_o,                                   // Internal reset, low in reset
    output logic bod_enable_o,                                    // Brown-out detector enable
    output logic ref_enable_o                                     // Bandgap reference enable
);
    import rst_wdt_pkg::*;

    logic chip_arst_n, flag_arst_n;
    logic [SYNC_N-1:0] async_in;
    logic [SYNC_N-1:0] sync_s;
    logic pin_low_s, bod_low_s, dbg_s, osc_s;

    // Pin and power-on act without a clock; brown-out needs filtering first
    assign chip_arst_n = rst_n_i & por_n_i & reset_pin_n_i; // RULE_01 RULE_25
    assign flag_arst_n = rst_n_i & por_n_i; // RULE_12

    assign async_in[SYN_PIN] = ~reset_pin_n_i;
    assign async_in[SYN_BOD] = bod_low_i;
    assign async_in[SYN_DBG] = debug_reset_i;
    assign async_in[SYN_OSC] = wdt_osc_i;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            logic q1;
            logic q2;
            always_ff @(posedge ref_clk_i or negedge flag_arst_n) begin
                if (!flag_arst_n) begin
                    q1 <= 1'b0;
                    q2 <= 1'b0;
                end else begin
                    q1 <= async_in[gi]; // RULE_26
                    q2 <= q1;
                end
            end
            assign sync_s[gi] = q2;
        end
    endgenerate

    assign pin_low_s = sync_s[SYN_PIN];
    assign bod_low_s = sync_s[SYN_BOD];
    assign dbg_s = sync_s[SYN_DBG];
    assign osc_s = sync_s[SYN_OSC];

    // Pulse width filters
    logic [FILT_W-1:0] pin_cnt, next_pin_cnt;
    logic [FILT_W-1:0] bod_cnt, next_bod_cnt;
    logic pin_active, bod_active, bod_en, safety2;

    assign bod_en = (brownout_level_fuse_i == BOD_LOW) || (brownout_level_fuse_i == BOD_MID)
                    || (brownout_level_fuse_i == BOD_HIGH); // RULE_03
    assign safety2 = watchdog_safety_fuse_i; // RULE_19
    assign pin_active = (pin_cnt == FILT_W'(RST_MIN_CYC));
    assign bod_active = (bod_cnt == FILT_W'(BOD_MIN_CYC)); // RULE_06

    always_comb begin
        next_pin_cnt = '0;
        next_bod_cnt = '0;
        if (pin_low_s) begin
            next_pin_cnt = pin_active ? pin_cnt : pin_cnt + 1'b1; // RULE_11
        end
        if (bod_low_s && bod_en) begin
            next_bod_cnt = bod_active ? bod_cnt : bod_cnt + 1'b1; // RULE_04 RULE_06
        end
    end

    always_ff @(posedge ref_clk_i or negedge flag_arst_n) begin
        if (!flag_arst_n) begin
            pin_cnt <= '0;
            bod_cnt <= '0;
        end else begin
            pin_cnt <= next_pin_cnt;
            bod_cnt <= next_bod_cnt;
        end
    end

    // Reset sequencer: hold, stretch, run
    seq_state_t state, next_state;
    logic [DLY_W-1:0] delay_cnt, next_delay_cnt;
    logic [DLY_W-1:0] delay_target;
    logic [2:0] delay_shift;
    logic [1:0] rsync;
    logic run_q, next_run;
    logic wdt_fire, src_active;

    assign delay_shift = {1'b0, startup_time_fuse_i} + {2'b00, clock_select_fuse_i[3]};
    assign delay_target = DLY_W'(TOUT_BASE_CYCLES) << delay_shift; // RULE_21
    assign src_active = bod_active | wdt_fire | dbg_s | pin_low_s | ~rsync[1]; // RULE_04

    always_comb begin
        next_state = state;
        next_delay_cnt = delay_cnt;
        case (state)
            ST_HOLD: begin
                next_delay_cnt = '0;
                if (!src_active) begin
                    next_state = ST_DELAY; // RULE_02 RULE_05 RULE_07
                end
            end
            ST_DELAY: begin
                if (src_active) begin
                    next_state = ST_HOLD;
                    next_delay_cnt = '0;
                end else if (delay_cnt == delay_target - 1'b1) begin
                    next_state = ST_RUN; // RULE_21
                end else begin
                    next_delay_cnt = delay_cnt + 1'b1;
                end
            end
            ST_RUN: begin
                if (src_active) begin
                    next_state = ST_HOLD; // RULE_18
                end
            end
            default: begin
                next_state = ST_HOLD;
                next_delay_cnt = '0;
            end
        endcase
        next_run = (next_state == ST_RUN);
    end

    always_ff @(posedge ref_clk_i or negedge chip_arst_n) begin
        if (!chip_arst_n) begin
            rsync <= 2'b00;
            state <= ST_HOLD;
            delay_cnt <= '0;
            run_q <= 1'b0;
        end else begin
            rsync <= {rsync[0], 1'b1}; // RULE_25
            state <= next_state;
            delay_cnt <= next_delay_cnt;
            run_q <= next_run;
        end
    end

    assign sys_reset_n_o = run_q;

    // Watchdog: ticks of its own oscillator, control with timed change
    logic osc_prev, wdt_tick;
    logic [WDT_W-1:0] wdt_cnt, next_wdt_cnt;
    logic [WDT_W-1:0] wdt_period;
    logic next_wdt_fire;
    logic [WDP_W-1:0] watchdog_prescale_field, next_wdp;
    logic watchdog_enable_bit, next_wde;
    logic [2:0] ce_cnt, next_ce_cnt;
    logic wde_eff, ce_open, apb_wr, wr_ctrl, wr_flags;

    assign wdt_tick = osc_s & ~osc_prev; // RULE_16
    assign wdt_period = WDT_W'(WDT_BASE_CYCLES) << watchdog_prescale_field; // RULE_22
    assign wde_eff = watchdog_enable_bit | safety2; // RULE_24
    assign ce_open = (ce_cnt != 3'h0);
    assign apb_wr = psel_i & penable_i & pwrite_i;
    assign wr_ctrl = apb_wr && (paddr_i == ADDR_WDT_CTRL);
    assign wr_flags = apb_wr && (paddr_i == ADDR_FLAGS);

    always_comb begin
        next_wdt_cnt = wdt_cnt;
        next_wdt_fire = 1'b0;
        if (!wde_eff || wdt_restart_i || !run_q || wdt_fire) begin
            next_wdt_cnt = '0; // RULE_17
        end else if (wdt_tick) begin
            if (wdt_cnt == wdt_period - 1'b1) begin
                next_wdt_cnt = '0;
                next_wdt_fire = 1'b1; // RULE_07 RULE_18
            end else begin
                next_wdt_cnt = wdt_cnt + 1'b1;
            end
        end
        next_wdp = watchdog_prescale_field;
        next_wde = watchdog_enable_bit;
        next_ce_cnt = ce_open ? ce_cnt - 1'b1 : 3'h0; // RULE_23
        if (wr_ctrl) begin
            if (ce_open && !pwdata_i[WATCHDOG_CHANGE_ENABLE_BIT]) begin
                next_wdp = pwdata_i[WDP_LSB +: WDP_W]; // RULE_23
                if (!safety2) begin
                    next_wde = pwdata_i[WDE_BIT]; // RULE_19
                end
            end else if (pwdata_i[WDE_BIT] && !safety2) begin
                next_wde = 1'b1; // RULE_19
            end
            if (pwdata_i[WATCHDOG_CHANGE_ENABLE_BIT] && pwdata_i[WDE_BIT]) begin
                next_ce_cnt = WATCHDOG_CHANGE_ENABLE_WINDOW; // RULE_23
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge flag_arst_n) begin
        if (!flag_arst_n) begin
            osc_prev <= 1'b0;
            wdt_cnt <= '0;
            wdt_fire <= 1'b0;
            watchdog_prescale_field <= WDP_RESET;
            watchdog_enable_bit <= 1'b0;
            ce_cnt <= 3'h0;
        end else begin
            osc_prev <= osc_s;
            wdt_cnt <= next_wdt_cnt;
            wdt_fire <= next_wdt_fire;
            watchdog_prescale_field <= next_wdp;
            watchdog_enable_bit <= next_wde;
            ce_cnt <= next_ce_cnt;
        end
    end

    // Reset cause flags, reference enables
    logic [FLAG_W-1:0] flags, next_flags;
    logic next_bod_enable, next_ref_enable;

    always_comb begin
        next_flags = flags;
        if (wr_flags) begin
            next_flags = flags & pwdata_i[FLAG_W-1:0]; // RULE_12
        end
        // Set after clear so an event in the clearing cycle is kept
        next_flags[FLAG_DBG] = next_flags[FLAG_DBG] | dbg_s; // RULE_08
        next_flags[FLAG_WDT] = next_flags[FLAG_WDT] | wdt_fire; // RULE_09
        next_flags[FLAG_BOD] = next_flags[FLAG_BOD] | bod_active; // RULE_10
        next_flags[FLAG_PIN] = next_flags[FLAG_PIN] | pin_active; // RULE_11
        next_bod_enable = bod_en;
        next_ref_enable = bod_en | comparator_bandgap_select_i | adc_enable_i; // RULE_14
    end

    always_ff @(posedge ref_clk_i or negedge flag_arst_n) begin
        if (!flag_arst_n) begin
            flags <= FLAGS_RESET; // RULE_12
            bod_enable_o <= 1'b0;
            ref_enable_o <= 1'b0;
        end else begin
            flags <= next_flags;
            bod_enable_o <= next_bod_enable;
            ref_enable_o <= next_ref_enable;
        end
    end

    // APB read path: data registered in the setup cycle, no wait states
    logic [DATA_W-1:0] next_prdata;
    logic mapped;

    assign mapped = (paddr_i == ADDR_FLAGS) || (paddr_i == ADDR_WDT_CTRL) || (paddr_i == ADDR_STATUS);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    always_comb begin
        next_prdata = prdata_o;
        if (psel_i && !penable_i) begin
            next_prdata = '0;
            case (paddr_i)
                ADDR_FLAGS: begin
                    next_prdata[FLAG_W-1:0] = flags;
                end
                ADDR_WDT_CTRL: begin
                    next_prdata[WDP_LSB +: WDP_W] = watchdog_prescale_field;
                    next_prdata[WDE_BIT] = wde_eff; // RULE_24
                    next_prdata[WATCHDOG_CHANGE_ENABLE_BIT] = ce_open;
                    next_prdata[CTRL_RES_MSB:CTRL_RES_LSB] = 3'h0; // RULE_20
                end
                ADDR_STATUS: begin
                    next_prdata[STAT_REF] = ref_enable_o;
                    next_prdata[STAT_BOD_EN] = bod_enable_o;
                    next_prdata[STAT_SAFETY2] = safety2;
                    next_prdata[STAT_RUN] = run_q;
                end
                default: begin
                    next_prdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= '0;
        end else begin
            prdata_o <= next_prdata;
        end
    end

    // Checks
    default clocking cb_main @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i || !por_n_i);

    sequence s_wdt_then_delay;
        (state == ST_HOLD && !wdt_fire) ##1 (state == ST_DELAY || state == ST_HOLD);
    endsequence
    sequence s_ce_window;
        ce_open [*4] ##1 (!ce_open || $past(wr_ctrl));
    endsequence

    property p_wdt_pulse;
        wdt_fire && state == ST_RUN |=> s_wdt_then_delay;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse not one cycle"); // RULE_07
    property p_wdt_flag;
        wdt_fire |=> flags[FLAG_WDT];
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set"); // RULE_09
    property p_pin_flag;
        $rose(pin_active) |=> flags[FLAG_PIN];
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set"); // RULE_11
    property p_bod_flag;
        bod_active |=> flags[FLAG_BOD] && !sys_reset_n_o;
    endproperty
    a_bod_flag: assert property (p_bod_flag) else $error("brown-out reset or flag missing"); // RULE_10
    property p_dbg_flag;
        dbg_s |=> flags[FLAG_DBG];
    endproperty
    a_dbg_flag: assert property (p_dbg_flag) else $error("debug flag not set"); // RULE_08
    property p_bod_filter;
        $rose(bod_active) |-> $past(bod_cnt) == FILT_W'(BOD_MIN_CYC - 1);
    endproperty
    a_bod_filter: assert property (p_bod_filter) else $error("brown-out filter too short"); // RULE_06
    property p_ce_window;
        wr_ctrl && pwdata_i[WATCHDOG_CHANGE_ENABLE_BIT] && pwdata_i[WDE_BIT] |=> s_ce_window;
    endproperty
    a_ce_window: assert property (p_ce_window) else $error("change window not four cycles"); // RULE_23
    property p_safety2;
        safety2 && psel_i && !penable_i && paddr_i == ADDR_WDT_CTRL |=> prdata_o[WDE_BIT];
    endproperty
    a_safety2: assert property (p_safety2) else $error("enable not read as one"); // RULE_24
    property p_reserved;
        psel_i && !penable_i && paddr_i == ADDR_WDT_CTRL |=> prdata_o[CTRL_RES_MSB:CTRL_RES_LSB] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // RULE_20
    property p_release;
        $rose(sys_reset_n_o) |-> $past(delay_cnt) == $past(delay_target) - 1'b1;
    endproperty
    a_release: assert property (p_release) else $error("reset released before delay"); // RULE_21
    property p_ref;
        $past(rst_n_i) && $past(por_n_i)
            |-> ref_enable_o == $past(bod_en || comparator_bandgap_select_i || adc_enable_i);
    endproperty
    a_ref: assert property (p_ref) else $error("reference enable wrong"); // RULE_14
    property p_wdt_clear;
        !wde_eff || !run_q || wdt_restart_i |=> wdt_cnt == '0;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog counter not cleared"); // RULE_17
endmodule : reset_source_watchdog_unit

/* File: include/rst_wdt_pkg.sv */
// Purpose: Shared constants for the reset source and watchdog unit
// Assumes: APB register bus with 32-bit data, system clock at 40 MHz
// Notes: Register offsets are byte addresses of aligned words
package rst_wdt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_WDT_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;

    // Reset cause flag bits
    localparam int FLAG_W = 5;
    localparam int FLAG_POR = 0;
    localparam int FLAG_PIN = 1;
    localparam int FLAG_BOD = 2;
    localparam int FLAG_WDT = 3;
    localparam int FLAG_DBG = 4;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h01;

    // Watchdog control fields
    localparam int WDP_W = 3;
    localparam int WDP_LSB = 0;
    localparam int WDE_BIT = 3;
    localparam int WATCHDOG_CHANGE_ENABLE_BIT = 4;
    localparam int CTRL_RES_LSB = 5;
    localparam int CTRL_RES_MSB = 7;
    localparam logic [WDP_W-1:0] WDP_RESET = 3'h0;
    localparam logic [2:0] WATCHDOG_CHANGE_ENABLE_WINDOW = 3'h4;

    // Status fields
    localparam int STAT_REF = 0;
    localparam int STAT_BOD_EN = 1;
    localparam int STAT_SAFETY2 = 2;
    localparam int STAT_RUN = 3;

    // Brown-out level fuse codes
    localparam logic [2:0] BOD_OFF = 3'h7;
    localparam logic [2:0] BOD_LOW = 3'h6;
    localparam logic [2:0] BOD_MID = 3'h5;
    localparam logic [2:0] BOD_HIGH = 3'h4;

    // Input synchroniser lanes
    localparam int SYNC_N = 4;
    localparam int SYN_PIN = 0;
    localparam int SYN_BOD = 1;
    localparam int SYN_DBG = 2;
    localparam int SYN_OSC = 3;

    // Timing
    localparam int CLK_FREQ_KHZ = 40000;
    localparam int T_RST_MIN_NS = 2500;
    localparam int T_BOD_MIN_NS = 2000;
    localparam int RST_MIN_CYC = (T_RST_MIN_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam int BOD_MIN_CYC = (T_BOD_MIN_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam int FILT_W = 8;
    localparam int WDT_W = 22;
    localparam int DLY_W = 24;

    typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_RUN} seq_state_t;
endpackage : rst_wdt_pkg

/* File: dv/supply_pin_model.sv */
// Purpose: Reset pin driver and supply detector model
// Assumes: Levels change by non-blocking assignment after a clock edge
// Notes: Watchdog oscillator runs free at 1 MHz
`timescale 1ns/1ps
module supply_pin_model (
    input wire logic clk_i,     // System clock
    output logic reset_pin_n_o, // Reset pin, pulled up when idle
    output logic por_n_o,       // Power-on detector, low in reset
    output logic bod_low_o,     // Supply below trigger
    output logic debug_reset_o, // Debug reset register bit
    output logic wdt_osc_o      // Watchdog oscillator
);
    initial begin
        reset_pin_n_o = 1'b1;
        por_n_o = 1'b1;
        bod_low_o = 1'b0;
        debug_reset_o = 1'b0;
        wdt_osc_o = 1'b0;
    end

    always #500 wdt_osc_o = ~wdt_osc_o;

    // Hold one source active for n cycles, then release all
    task pulse(input int sel, input int n);
        @(posedge clk_i);
        case (sel)
            0: reset_pin_n_o <= 1'b0;
            1: por_n_o <= 1'b0;
            2: bod_low_o <= 1'b1;
            default: debug_reset_o <= 1'b1;
        endcase
        repeat (n) @(posedge clk_i);
        reset_pin_n_o <= 1'b1;
        por_n_o <= 1'b1;
        bod_low_o <= 1'b0;
        debug_reset_o <= 1'b0;
    endtask : pulse
endmodule : supply_pin_model

/* File: dv/reset_source_watchdog_unit_tb.sv */
// Purpose: Self-checking bench for the reset source and watchdog unit
// Assumes: Short delay and watchdog bases; fuses change only around a reset
// Notes: Watchdog expiry is judged in a window of whole oscillator ticks
`timescale 1ns/1ps
module reset_source_watchdog_unit_tb;
    import rst_wdt_pkg::*;
    localparam int TB = 8;
    localparam int WB = 4;
    logic ref_clk_i = 1'b0;
    logic rst_n_i, psel_i, penable_i, pwrite_i, wdt_restart_i, watchdog_safety_fuse_i;
    logic comparator_bandgap_select_i, adc_enable_i, last_err;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, pslverr_o, sys_reset_n_o, bod_enable_o, ref_enable_o;
    logic reset_pin_n_i, por_n_i, bod_low_i, debug_reset_i, wdt_osc_i;
    logic [2:0] brownout_level_fuse_i;
    logic [1:0] startup_time_fuse_i;
    logic [3:0] clock_select_fuse_i;
    int fail_count = 0;
    int tests_run = 0;
    int drops = 0;
    integer seed = 32'h2f46;

    reset_source_watchdog_unit #(.WDT_BASE_CYCLES(WB), .TOUT_BASE_CYCLES(TB)) dut (
        .ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .reset_pin_n_i, .por_n_i, .bod_low_i, .debug_reset_i, .wdt_osc_i, .wdt_restart_i,
        .brownout_level_fuse_i, .watchdog_safety_fuse_i, .startup_time_fuse_i, .clock_select_fuse_i,
        .comparator_bandgap_select_i, .adc_enable_i, .sys_reset_n_o, .bod_enable_o, .ref_enable_o);

    supply_pin_model m (.clk_i(ref_clk_i), .reset_pin_n_o(reset_pin_n_i), .por_n_o(por_n_i),
        .bod_low_o(bod_low_i), .debug_reset_o(debug_reset_i), .wdt_osc_o(wdt_osc_i));

    always #12.5 ref_clk_i = ~ref_clk_i;
    always @(negedge sys_reset_n_o) drops <= drops + 1;

    function int tout();
        return TB << (startup_time_fuse_i + clock_select_fuse_i[3]);
    endfunction : tout

    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        last_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask : rd

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    // Cycles from now until the internal reset is released
    task run_chk();
        int c;
        c = 0;
        while (sys_reset_n_o !== 1'b1 && c < 2000) begin
            @(posedge ref_clk_i);
            c++;
        end
        check(c >= tout() && c <= tout() + 6, 1'b1);
    endtask : run_chk

    task hard_reset();
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
    endtask : hard_reset

    task kick();
        @(posedge ref_clk_i);
        wdt_restart_i <= 1'b1;
        @(posedge ref_clk_i);
        wdt_restart_i <= 1'b0;
    endtask : kick

    // Expiry after n oscillator ticks with no restart
    task wd_chk(input int n);
        int c, d0;
        kick();
        d0 = drops;
        c = 0;
        while (drops == d0 && c < 1000) begin
            @(posedge ref_clk_i);
            c++;
        end
        check(c >= (n - 1) * 40 - 5 && c <= n * 40 + 15, 1'b1);
    endtask : wd_chk

    task finish_test();
        $display("counts: tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        #1500000;
        fail_count++;
        finish_test();
    end

    initial begin
        logic [31:0] r;
        int n, d0;
        {rst_n_i, psel_i, penable_i, pwrite_i, wdt_restart_i, watchdog_safety_fuse_i} = 6'h00;
        {comparator_bandgap_select_i, adc_enable_i, paddr_i, pwdata_i} = '0;
        {startup_time_fuse_i, clock_select_fuse_i, brownout_level_fuse_i} = {2'h1, 4'h0, BOD_OFF};
        for (n = 0; n < 8; n++) begin
            r = $random(seed);
            comparator_bandgap_select_i <= r[0];
            adc_enable_i <= r[1];
            brownout_level_fuse_i <= n[2:0];
            hard_reset();
            repeat (3) @(posedge ref_clk_i);
            check({ref_enable_o, bod_enable_o}, {(n inside {4, 5, 6}) | r[0] | r[1], n inside {4, 5, 6}});
        end
        run_chk();
        rd(ADDR_FLAGS, 32'h01);
        wr(ADDR_FLAGS, 32'h0);
        rd(ADDR_FLAGS, 32'h0);
        apb(1'b0, 8'h40, 32'h0, r);
        check(r, 32'h0);
        check({31'h0, last_err}, 32'h1);
        $display("test registers done");
        d0 = drops;
        m.pulse(0, 20);
        run_chk();
        rd(ADDR_FLAGS, 32'h0);
        m.pulse(0, 120);
        run_chk();
        rd(ADDR_FLAGS, 32'h02);
        check(drops - d0, 2);
        brownout_level_fuse_i <= BOD_LOW;
        hard_reset();
        run_chk();
        wr(ADDR_FLAGS, 32'h0);
        rd(ADDR_STATUS, 32'h0b);
        d0 = drops;
        m.pulse(2, 40);
        check(drops - d0, 0);
        m.pulse(2, 120);
        check(drops - d0, 1);
        run_chk();
        rd(ADDR_FLAGS, 32'h04);
        wr(ADDR_FLAGS, 32'h0);
        m.pulse(3, 10);
        run_chk();
        rd(ADDR_FLAGS, 32'h10);
        m.pulse(1, 5);
        run_chk();
        rd(ADDR_FLAGS, 32'h01);
        $display("test sources done");
        wr(ADDR_FLAGS, 32'h0);
        wr(ADDR_WDT_CTRL, 32'he8);
        rd(ADDR_WDT_CTRL, 32'h08);
        d0 = drops;
        repeat (20) begin
            kick();
            repeat (58) @(posedge ref_clk_i);
        end
        check(drops - d0, 0);
        wd_chk(WB);
        run_chk();
        rd(ADDR_FLAGS, 32'h08);
        wr(ADDR_WDT_CTRL, 32'h18);
        wr(ADDR_WDT_CTRL, 32'h09);
        rd(ADDR_WDT_CTRL, 32'h09);
        wd_chk(WB << 1);
        run_chk();
        wr(ADDR_WDT_CTRL, 32'h19);
        repeat (6) @(posedge ref_clk_i);
        wr(ADDR_WDT_CTRL, 32'h00);
        rd(ADDR_WDT_CTRL, 32'h09);
        wr(ADDR_WDT_CTRL, 32'h19);
        wr(ADDR_WDT_CTRL, 32'h00);
        d0 = drops;
        repeat (600) @(posedge ref_clk_i);
        check(drops - d0, 0);
        $display("test watchdog level 1 done");
        watchdog_safety_fuse_i <= 1'b1;
        hard_reset();
        run_chk();
        rd(ADDR_WDT_CTRL, 32'h08);
        wr(ADDR_WDT_CTRL, 32'h18);
        wr(ADDR_WDT_CTRL, 32'h02);
        rd(ADDR_WDT_CTRL, 32'h0a);
        $display("test watchdog level 2 done");
        finish_test();
    end
endmodule : reset_source_watchdog_unit_tb
